// File: pcpl_regs.svh
`ifndef PCPL_REGS_SVH
`define PCPL_REGS_SVH

// -------------------------------------------------------------------
// Management frame layout
// -------------------------------------------------------------------
`define PCPL_PRE_MIN 32
`define PCPL_HDR_LAST 4'hb
`define PCPL_WR_LAST 5'h11
`define PCPL_RD_LAST 5'h0f
`define PCPL_OP_WRITE 2'h1
`define PCPL_OP_READ 2'h2
`define PCPL_OP_MSB 11
`define PCPL_OP_LSB 10
`define PCPL_PHY_MSB 9
`define PCPL_PHY_LSB 5
`define PCPL_REG_MSB 4
`define PCPL_REG_LSB 0

// -------------------------------------------------------------------
// Synchroniser reset levels {reset_n, pin, mdio, mdc}
// -------------------------------------------------------------------
`define PCPL_SYNC_RST 4'he
`define PCPL_SY_MDC 0
`define PCPL_SY_MDIO 1
`define PCPL_SY_PIN 2
`define PCPL_SY_RSTN 3

`endif

// File: pcpl_pkg.sv
package pcpl_pkg;

  typedef enum logic [2:0] {
    PCPL_S_PRE = 3'b000,
    PCPL_S_ST  = 3'b001,
    PCPL_S_HDR = 3'b010,
    PCPL_S_WR  = 3'b011,
    PCPL_S_TA1 = 3'b100,
    PCPL_S_TA2 = 3'b101,
    PCPL_S_RD  = 3'b110
  } pcpl_state_t;

endpackage : pcpl_pkg

// File: pcpl_sync.sv
module pcpl_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Only the second stage reads the first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : pcpl_sync

// File: pcpl_top.sv
`include "pcpl_regs.svh"

// How it works
// - Data line released unless device answers.
// - Dual pin defaults to power-down input.
// - Pin low in power-down role powers down.
// - Interrupt role drives pin low when pending.
// - Reset pin low re-initialises frame engine and pin logic.
module pcpl_top
  import pcpl_pkg::*;
#(
  parameter int PRE_MIN = `PCPL_PRE_MIN
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic irq_or_powerdown_pin_in,
  output logic irq_or_powerdown_pin_out,
  output logic irq_or_powerdown_pin_oe,
  input wire logic hw_reset_pin_n,
  input wire logic cfg_irq_mode,
  input wire logic irq_pending,
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] reg_rd_data,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wr_data,
  output logic reg_wr_pulse,
  output logic reg_rd_pulse,
  output logic power_down,
  output logic regs_init
);

  // -------------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------------
  if (PRE_MIN < 1 || PRE_MIN > 63) begin : g_bad_pre
    $error("PRE_MIN must lie in 1..63");
  end

  // -------------------------------------------------------------------
  // Pin synchronisers and management clock edge
  // -------------------------------------------------------------------
  logic [3:0] sync_q;
  logic mdc_s, mdio_s, pin_s, rst_s, init;
  logic mdc_d_reg;
  logic mdc_rise;

  pcpl_sync #(.W(4), .RST_VAL(`PCPL_SYNC_RST)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({hw_reset_pin_n, irq_or_powerdown_pin_in, mdio_in, mdc}),
    .q(sync_q)
  );

  assign mdc_s = sync_q[`PCPL_SY_MDC];
  assign mdio_s = sync_q[`PCPL_SY_MDIO];
  assign pin_s = sync_q[`PCPL_SY_PIN];
  assign rst_s = sync_q[`PCPL_SY_RSTN];
  assign init = ~rst_s;

  assign mdc_rise = mdc_s & ~mdc_d_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_d_reg <= 1'b0;
    end else begin
      mdc_d_reg <= mdc_s;
    end
  end

  // -------------------------------------------------------------------
  // Management frame engine
  // -------------------------------------------------------------------
  pcpl_state_t state_reg, state_next;
  logic [5:0] pre_reg, pre_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [11:0] hdr_reg, hdr_next;
  logic [15:0] sh_reg, sh_next;
  logic mdio_out_reg, mdio_out_next;
  logic mdio_oe_reg, mdio_oe_next;
  logic [4:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic [11:0] hdr_shift;
  logic [15:0] sh_in;
  logic hdr_mine;
  logic [1:0] hdr_op;

  assign hdr_shift = {hdr_reg[10:0], mdio_s};
  assign sh_in = {sh_reg[14:0], mdio_s};
  assign hdr_op = hdr_shift[`PCPL_OP_MSB:`PCPL_OP_LSB];
  assign hdr_mine = (hdr_shift[`PCPL_PHY_MSB:`PCPL_PHY_LSB] == phy_addr);

  always_comb begin
    state_next = state_reg;
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    sh_next = sh_reg;
    mdio_out_next = mdio_out_reg;
    mdio_oe_next = mdio_oe_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    if (mdc_rise) begin
      case (state_reg)
        PCPL_S_PRE: begin
          if (mdio_s) begin
            if (pre_reg != 6'h3f) begin
              pre_next = pre_reg + 6'h01;
            end
          end else begin
            if (pre_reg >= 6'(PRE_MIN)) begin
              state_next = PCPL_S_ST;
            end
            pre_next = 6'h00;
          end
        end
        PCPL_S_ST: begin
          state_next = mdio_s ? PCPL_S_HDR : PCPL_S_PRE;
          cnt_next = 5'({1'b0, `PCPL_HDR_LAST});
        end
        PCPL_S_HDR: begin
          hdr_next = hdr_shift;
          if (cnt_reg == 5'h00) begin
            addr_next = hdr_shift[`PCPL_REG_MSB:`PCPL_REG_LSB];
            if (hdr_mine && hdr_op == `PCPL_OP_READ) begin
              rd_next = 1'b1;
              state_next = PCPL_S_TA1;
            end else if (hdr_mine && hdr_op == `PCPL_OP_WRITE) begin
              cnt_next = `PCPL_WR_LAST;
              state_next = PCPL_S_WR;
            end else begin
              // Frames for other addresses, or with an opcode other than read or write, are not followed further
              state_next = PCPL_S_PRE;
            end
          end else begin
            cnt_next = cnt_reg - 5'h01;
          end
        end
        PCPL_S_WR: begin
          // Turnaround bits shift through and fall off the top
          sh_next = sh_in;
          if (cnt_reg == 5'h00) begin
            wdata_next = sh_in;
            wr_next = 1'b1;
            state_next = PCPL_S_PRE;
          end else begin
            cnt_next = cnt_reg - 5'h01;
          end
        end
        PCPL_S_TA1: begin
          mdio_oe_next = 1'b1;
          mdio_out_next = 1'b0;
          sh_next = reg_rd_data;
          state_next = PCPL_S_TA2;
        end
        PCPL_S_TA2: begin
          mdio_out_next = sh_reg[15];
          sh_next = {sh_reg[14:0], 1'b0};
          cnt_next = `PCPL_RD_LAST;
          state_next = PCPL_S_RD;
        end
        PCPL_S_RD: begin
          if (cnt_reg == 5'h00) begin
            mdio_oe_next = 1'b0;
            mdio_out_next = 1'b1;
            state_next = PCPL_S_PRE;
          end else begin
            mdio_out_next = sh_reg[15];
            sh_next = {sh_reg[14:0], 1'b0};
            cnt_next = cnt_reg - 5'h01;
          end
        end
        default: begin
          state_next = PCPL_S_PRE;
          mdio_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PCPL_S_PRE;
      pre_reg <= 6'h00;
      cnt_reg <= 5'h00;
      hdr_reg <= 12'h000;
      sh_reg <= 16'h0000;
      mdio_out_reg <= 1'b1;
      mdio_oe_reg <= 1'b0;
      addr_reg <= 5'h00;
      wdata_reg <= 16'h0000;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (init) begin
      state_reg <= PCPL_S_PRE;
      pre_reg <= 6'h00;
      cnt_reg <= 5'h00;
      hdr_reg <= 12'h000;
      sh_reg <= 16'h0000;
      mdio_out_reg <= 1'b1;
      mdio_oe_reg <= 1'b0;
      addr_reg <= 5'h00;
      wdata_reg <= 16'h0000;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
      sh_reg <= sh_next;
      mdio_out_reg <= mdio_out_next;
      mdio_oe_reg <= mdio_oe_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // -------------------------------------------------------------------
  // Dual-purpose pin and reset status
  // -------------------------------------------------------------------
  logic cfg_mode_reg, pd_reg, pin_oe_reg, pin_out_reg, init_reg;
  logic pd_next, pin_oe_next;

  assign pd_next = ~cfg_mode_reg & ~pin_s;
  assign pin_oe_next = cfg_mode_reg & irq_pending;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_mode_reg <= 1'b0;
      pd_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      init_reg <= 1'b1;
    end else begin
      cfg_mode_reg <= cfg_irq_mode & ~init;
      pd_reg <= pd_next & ~init;
      pin_oe_reg <= pin_oe_next & ~init;
      pin_out_reg <= 1'b0;
      init_reg <= init;
    end
  end

  assign mdio_out = mdio_out_reg;
  assign mdio_oe = mdio_oe_reg;
  assign irq_or_powerdown_pin_out = pin_out_reg;
  assign irq_or_powerdown_pin_oe = pin_oe_reg;
  assign reg_addr = addr_reg;
  assign reg_wr_data = wdata_reg;
  assign reg_wr_pulse = wr_reg;
  assign reg_rd_pulse = rd_reg;
  assign power_down = pd_reg;
  assign regs_init = init_reg;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_mdio_released: assert property (
    (state_reg != PCPL_S_TA2 && state_reg != PCPL_S_RD) |-> !mdio_oe_reg)
    else $error("management data driven outside a read answer");
  chk_ta_zero: assert property (
    (rst_s && state_reg == PCPL_S_TA1 && mdc_rise) |=> (mdio_oe_reg && !mdio_out_reg))
    else $error("turnaround zero not driven");
  chk_pd_default: assert property (
    !cfg_mode_reg |-> !pin_oe_reg)
    else $error("pin driven in power-down role");
  chk_pd_follow: assert property (
    (rst_s && !cfg_mode_reg) |=> (pd_reg == !$past(pin_s)))
    else $error("power-down does not follow pin");
  chk_irq_drive: assert property (
    (rst_s && cfg_mode_reg && irq_pending) |=> (pin_oe_reg && !pin_out_reg))
    else $error("pending interrupt not driven low");
  chk_irq_release: assert property (
    !irq_pending |=> !pin_oe_reg)
    else $error("pin driven with nothing pending");
  chk_init_clear: assert property (
    !rst_s |=> (state_reg == PCPL_S_PRE && !pd_reg && !cfg_mode_reg && regs_init))
    else $error("reset pin did not re-initialise");

endmodule : pcpl_top

// File: pcpl_station.sv
module pcpl_station (
  output logic mdc,
  output logic st_out,
  output logic st_oe,
  input wire logic mdio_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rd_word;
  logic ta_bit;
  initial begin
    mdc = 1'b0;
    st_out = 1'b1;
    st_oe = 1'b0;
  end
  // -----------------------------------------------------------------
  // Bit timing
  // -----------------------------------------------------------------
  // slow unrelated clock
  task automatic tick(input logic b, input logic drv, output logic seen);
    mdc = 1'b0;
    st_oe = drv;
    st_out = b;
    #80;
    seen = mdio_wire;
    mdc = 1'b1;
    #80;
  endtask : tick
  task automatic frame(input int pre, input logic [13:0] hdr, input logic [15:0] wd);
    logic [17:0] tail;
    logic s;
    logic rd;
    tail = {2'h2, wd};
    rd = (hdr[11:10] == 2'h2);
    for (int i = 0; i < pre; i++) begin
      tick(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) begin
      tick(hdr[i], 1'b1, s);
    end
    for (int i = 17; i >= 0; i--) begin
      tick(tail[i], !rd, s);
      if (i == 16) begin
        ta_bit = s;
      end
      if (i < 16) begin
        rd_word[i[3:0]] = s;
      end
    end
    // Clock stands low between frames
    mdc = 1'b0;
    st_oe = 1'b0;
    #80;
  endtask : frame
endmodule : pcpl_station

// File: pcpl_top_test.sv
module pcpl_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] MY_ADDR = 5'h01;
  logic clk, arst_n, mdc, st_out, st_oe, mdio_wire, mdio_out, mdio_oe;
  logic pin_out, pin_oe, pin_wire, ext_low, hw_reset_pin_n, cfg_irq_mode, irq_pending;
  logic reg_wr_pulse, reg_rd_pulse, power_down, regs_init;
  logic [15:0] reg_rd_data, reg_wr_data, wr_data;
  logic [4:0] reg_addr, wr_addr;
  int err_count, total_checks, wr_cnt, rd_cnt, oe_cnt, clash_cnt, ref_cnt;
  logic ref_clock_input;
  // Pull-ups give the idle high level of both shared lines
  assign mdio_wire = mdio_oe ? mdio_out : (st_oe ? st_out : 1'b1);
  assign pin_wire = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;

  pcpl_top i_pcpl_top (.clk(clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_or_powerdown_pin_in(pin_wire),
    .irq_or_powerdown_pin_out(pin_out), .irq_or_powerdown_pin_oe(pin_oe),
    .hw_reset_pin_n(hw_reset_pin_n), .cfg_irq_mode(cfg_irq_mode),
    .irq_pending(irq_pending), .phy_addr(MY_ADDR), .reg_rd_data(reg_rd_data),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_pulse(reg_wr_pulse),
    .reg_rd_pulse(reg_rd_pulse), .power_down(power_down), .regs_init(regs_init));
  pcpl_station i_pcpl_station (.mdc(mdc), .st_out(st_out), .st_oe(st_oe),
    .mdio_wire(mdio_wire));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // board reference, 25 MHz
  // Offset so its edges never meet a clk edge
  initial begin
    ref_clock_input = 1'b0;
    #7;
    forever #20 ref_clock_input = ~ref_clock_input;
  end
  always @(posedge ref_clock_input) ref_cnt++;
  // Pulses last a full cycle, so the falling edge sees them race-free
  always @(negedge clk) begin
    if (reg_wr_pulse === 1'b1) begin
      wr_cnt++;
      wr_addr = reg_addr;
      wr_data = reg_wr_data;
    end
    if (reg_rd_pulse === 1'b1) rd_cnt++;
    if (mdio_oe === 1'b1) oe_cnt++;
    if (mdio_oe === 1'b1 && st_oe) clash_cnt++;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_defaults();
    check(regs_init, 1'b0);
    check(pin_oe, 1'b0);
    check(power_down, 1'b0);
    check(mdio_oe, 1'b0);
    ref_cnt = 0;
    step(100);
    check(ref_cnt, 25);
  endtask : t_defaults
  task automatic t_powerdown();
    irq_pending = 1'b1;
    ext_low = 1'b1;
    step(5);
    check(power_down, 1'b1);
    check(pin_oe, 1'b0);
    ext_low = 1'b0;
    step(5);
    check(power_down, 1'b0);
    irq_pending = 1'b0;
  endtask : t_powerdown
  task automatic t_irq();
    cfg_irq_mode = 1'b1;
    step(3);
    check(pin_wire, 1'b1);
    irq_pending = 1'b1;
    step(2);
    check({pin_oe, pin_out, pin_wire}, 3'b100);
    check(power_down, 1'b0);
    irq_pending = 1'b0;
    step(2);
    check({pin_oe, pin_wire}, 2'b01);
  endtask : t_irq
  task automatic t_hw_reset();
    irq_pending = 1'b1;
    step(3);
    hw_reset_pin_n = 1'b0;
    step(5);
    check({regs_init, pin_oe}, 2'b10);
    step(995);
    hw_reset_pin_n = 1'b1;
    step(6);
    check({regs_init, pin_oe}, 2'b01);
    cfg_irq_mode = 1'b0;
    irq_pending = 1'b0;
    step(3);
  endtask : t_hw_reset
  task automatic t_write();
    i_pcpl_station.frame(32, {2'h1, 2'h1, MY_ADDR, 5'h1a}, 16'hc3a5);
    step(10);
    check(wr_cnt, 1);
    check({wr_addr, wr_data}, {5'h1a, 16'hc3a5});
    check(oe_cnt, 0);
  endtask : t_write
  task automatic t_read();
    reg_rd_data = 16'h5a3c;
    i_pcpl_station.frame(32, {2'h1, 2'h2, MY_ADDR, 5'h07}, 16'h0000);
    step(10);
    check(rd_cnt, 1);
    check(reg_addr, 5'h07);
    check(i_pcpl_station.ta_bit, 1'b0);
    check(i_pcpl_station.rd_word, 16'h5a3c);
    check(mdio_oe, 1'b0);
    check(clash_cnt, 0);
  endtask : t_read
  task automatic t_refused();
    logic [13:0] hdr [4];
    hdr = '{{4'h6, 5'h02, 5'h03}, {4'h4, MY_ADDR, 5'h03}, {4'h7, MY_ADDR, 5'h03},
      {4'h5, MY_ADDR, 5'h03}};
    oe_cnt = 0;
    // Zero data, so no tail of ones pads the short preamble that follows
    for (int k = 0; k < 4; k++) begin
      i_pcpl_station.frame(k == 3 ? 31 : 32, hdr[k], 16'h0000);
    end
    step(10);
    check(wr_cnt, 1);
    check(rd_cnt, 1);
    check(oe_cnt, 0);
  endtask : t_refused

  initial begin
    arst_n = 1'b0;
    hw_reset_pin_n = 1'b1;
    cfg_irq_mode = 1'b0;
    irq_pending = 1'b0;
    ext_low = 1'b0;
    reg_rd_data = 16'h0000;
    step(8);
    arst_n = 1'b1;
    step(4);
    t_defaults();
    t_powerdown();
    t_irq();
    t_hw_reset();
    t_write();
    t_read();
    t_refused();
    summarize();
  end
  // Watchdog: the whole run needs well under 300 us
  initial begin
    #300000;
    err_count++;
    $display("[FAIL] %0t ns: run timed out", $time);
    summarize();
  end
endmodule : pcpl_top_test
